// File: design/pmc_cfg_regs.sv
// Power management capability register slice behind an AXI4-Lite slave
//
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/1ns
module pmc_cfg_regs (
  input  wire logic                           CLK,
  input  wire logic                           RST_N,
  // Port strap and locked-write path
  input  wire logic                           IS_UPSTREAM,
  input  wire logic                           LOCKED_WRITE_EN,
  // Event forwarding
  input  wire logic [1:0]                     POWER_STATE,
  input  wire logic                           IN_D3COLD,
  input  wire logic                           PME_EVENT_IN,
  output      logic                           PME_FORWARD,
  // AXI4-Lite slave
  input  wire logic [pmc_pkg::PMC_ADDR_W-1:0] AWADDR,
  input  wire logic                           AWVALID,
  output      logic                           AWREADY,
  input  wire logic [pmc_pkg::PMC_DATA_W-1:0] WDATA,
  input  wire logic [pmc_pkg::PMC_STRB_W-1:0] WSTRB,
  input  wire logic                           WVALID,
  output      logic                           WREADY,
  output      logic [1:0]                     BRESP,
  output      logic                           BVALID,
  input  wire logic                           BREADY,
  input  wire logic [pmc_pkg::PMC_ADDR_W-1:0] ARADDR,
  input  wire logic                           ARVALID,
  output      logic                           ARREADY,
  output      logic [pmc_pkg::PMC_DATA_W-1:0] RDATA,
  output      logic [1:0]                     RRESP,
  output      logic                           RVALID,
  input  wire logic                           RREADY
);
  import pmc_pkg::*;

  typedef enum logic {
    WR_COLLECT,
    WR_RESP
  } pmc_wr_state_type;

  typedef enum logic {
    RD_IDLE,
    RD_RESP
  } pmc_rd_state_type;

  // ==========================================================================
  // Address decode
  function automatic pmc_sel_type decode_addr(input logic [PMC_ADDR_W-1:0] addr);
    pmc_sel_type sel;
    sel = PMC_SEL_NONE;
    if (addr[PMC_ADDR_W-1:10] != 2'h0 || addr[1:0] != 2'h0) begin
      sel = PMC_SEL_NONE;
    end else if (addr[9:2] == PMC_IDX_LINK_CTL2) begin
      sel = PMC_SEL_LINK_CTL2;
    end else if (addr[9:2] == PMC_IDX_LINK_STS2) begin
      sel = PMC_SEL_LINK_STS2;
    end else if (addr[9:2] == PMC_IDX_SLOT_CAP2) begin
      sel = PMC_SEL_SLOT_CAP2;
    end else if (addr[9:2] == PMC_IDX_SLOT_CTL2) begin
      sel = PMC_SEL_SLOT_CTL2;
    end else if (addr[9:2] == PMC_IDX_SLOT_STS2) begin
      sel = PMC_SEL_SLOT_STS2;
    end else if (addr[9:2] == PMC_IDX_PM_CAP_HDR) begin
      sel = PMC_SEL_PM_CAP_HDR;
    end
    return sel;
  endfunction : decode_addr

  // ==========================================================================
  // Storage for the locked-writable fields
  logic [7:0]       next_capability_pointer;
  logic             device_specific_init_flag;
  logic [4:0]       pme_support_advertised;

  // Write channel holding registers
  pmc_wr_state_type wr_state;
  logic             aw_held;
  logic             w_held;
  logic [PMC_ADDR_W-1:0] aw_addr;
  logic [PMC_DATA_W-1:0] w_data;
  logic [PMC_STRB_W-1:0] w_strb;
  pmc_sel_type      wr_sel;
  logic             wr_fire;
  logic             locked_write_access;

  pmc_rd_state_type rd_state;
  pmc_sel_type      rd_sel;
  logic [31:0]      cap_hdr_word;
  logic [31:0]      next_rdata;

  // ==========================================================================
  // Capability header image
  always_comb begin
    cap_hdr_word = PMC_RESERVED_VALUE;
    cap_hdr_word[PMC_CAP_IDENT_LSB +: 8] = PMC_CAP_IDENT_VALUE;
    cap_hdr_word[PMC_NEXT_PTR_LSB +: 8] = next_capability_pointer;
    cap_hdr_word[PMC_SPEC_VERSION_LSB +: 3] = PMC_SPEC_VERSION_VALUE;
    cap_hdr_word[PMC_EVCLK_BIT] = PMC_EVCLK_VALUE;
    cap_hdr_word[PMC_RSVD20_BIT] = 1'h0;
    cap_hdr_word[PMC_DEV_INIT_BIT] = device_specific_init_flag;
    cap_hdr_word[PMC_AUX_CURRENT_LSB +: 3] = PMC_AUX_CURRENT_VALUE;
    cap_hdr_word[PMC_D1_BIT] = PMC_D1_VALUE;
    cap_hdr_word[PMC_D2_BIT] = PMC_D2_VALUE;
    cap_hdr_word[PMC_PME_SUP_LSB +: 5] = pme_support_advertised;
  end

  // ==========================================================================
  // Write channel
  assign wr_sel              = decode_addr(aw_addr);
  assign wr_fire             = (wr_state == WR_COLLECT) && aw_held && w_held;
  // locked fields only move with the locked path open
  assign locked_write_access = wr_fire && LOCKED_WRITE_EN && (wr_sel == PMC_SEL_PM_CAP_HDR);

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
      AWREADY <= 1'b1;
    end else if (AWVALID && AWREADY) begin
      aw_held <= 1'b1;
      aw_addr <= AWADDR;
      AWREADY <= 1'b0;
    end else if (BVALID && BREADY) begin
      AWREADY <= 1'b1;
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
      WREADY <= 1'b1;
    end else if (WVALID && WREADY) begin
      w_held <= 1'b1;
      w_data <= WDATA;
      w_strb <= WSTRB;
      WREADY <= 1'b0;
    end else if (BVALID && BREADY) begin
      WREADY <= 1'b1;
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      wr_state <= WR_COLLECT;
      BVALID   <= 1'b0;
      BRESP    <= PMC_RESP_OKAY;
    end else begin
      case (wr_state)
        WR_COLLECT: begin
          if (wr_fire) begin
            wr_state <= WR_RESP;
            BVALID   <= 1'b1;
            // Read-only targets answer OKAY; only holes get an error
            BRESP    <= (wr_sel == PMC_SEL_NONE) ? PMC_RESP_SLVERR : PMC_RESP_OKAY;
          end
        end
        WR_RESP: begin
          if (BREADY) begin
            wr_state <= WR_COLLECT;
            BVALID   <= 1'b0;
          end
        end
        default: begin
          wr_state <= WR_COLLECT;
        end
      endcase
    end
  end

  // ==========================================================================
  // Locked-writable fields
  // Strap sampled in the clocked reset branch, never asynchronously
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      // downstream points at the next structure
      next_capability_pointer <= IS_UPSTREAM ? PMC_NEXT_PTR_UPSTREAM : PMC_NEXT_PTR_DOWNSTRM;
    end else if (locked_write_access && w_strb[1]) begin
      next_capability_pointer <= w_data[PMC_NEXT_PTR_LSB +: 8];
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      device_specific_init_flag <= PMC_DEV_INIT_RESET;
    end else if (locked_write_access && w_strb[2]) begin
      // only the locked path changes it
      device_specific_init_flag <= w_data[PMC_DEV_INIT_BIT];
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      pme_support_advertised <= PMC_PME_SUP_RESET;
    end else if (locked_write_access && w_strb[3]) begin
      pme_support_advertised <= w_data[PMC_PME_SUP_LSB +: 5];
    end
  end

  // ==========================================================================
  // Read channel
  assign rd_sel = decode_addr(ARADDR);

  always_comb begin
    next_rdata = PMC_RESERVED_VALUE;
    if (rd_sel == PMC_SEL_PM_CAP_HDR) begin
      next_rdata = cap_hdr_word;
    end else begin
      // second-generation link and slot registers read zero
      next_rdata = PMC_RESERVED_VALUE;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      rd_state <= RD_IDLE;
      ARREADY  <= 1'b1;
      RVALID   <= 1'b0;
      RDATA    <= '0;
      RRESP    <= PMC_RESP_OKAY;
    end else begin
      case (rd_state)
        RD_IDLE: begin
          if (ARVALID) begin
            rd_state <= RD_RESP;
            ARREADY  <= 1'b0;
            RVALID   <= 1'b1;
            RDATA    <= next_rdata;
            RRESP    <= (rd_sel == PMC_SEL_NONE) ? PMC_RESP_SLVERR : PMC_RESP_OKAY;
          end
        end
        RD_RESP: begin
          if (RREADY) begin
            rd_state <= RD_IDLE;
            ARREADY  <= 1'b1;
            RVALID   <= 1'b0;
          end
        end
        default: begin
          rd_state <= RD_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // Event forwarding
  // Follows the reset mask, not the advertised copy, so software cannot
  // widen or narrow real behaviour by rewriting the field
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      PME_FORWARD <= 1'b0;
    end else begin
      // gated by the default state set
      PME_FORWARD <= PME_EVENT_IN && !IN_D3COLD &&
                     ((POWER_STATE == PMC_PSTATE_D0 && PMC_PME_SUP_RESET[0]) ||
                      (POWER_STATE == PMC_PSTATE_D3HOT && PMC_PME_SUP_RESET[3]));
    end
  end

endmodule : pmc_cfg_regs

// File: design/pmc_pkg.sv
// Constants and types for the power management capability register slice
package pmc_pkg;

  // ==========================================================================
  // Bus geometry
  localparam int unsigned PMC_ADDR_W = 12;
  localparam int unsigned PMC_DATA_W = 32;
  localparam int unsigned PMC_STRB_W = 4;

  // ==========================================================================
  // Register indices; byte address is four times the index
  localparam logic [7:0] PMC_IDX_LINK_CTL2  = 8'h70;
  localparam logic [7:0] PMC_IDX_LINK_STS2  = 8'h72;
  localparam logic [7:0] PMC_IDX_SLOT_CAP2  = 8'h74;
  localparam logic [7:0] PMC_IDX_SLOT_CTL2  = 8'h78;
  localparam logic [7:0] PMC_IDX_SLOT_STS2  = 8'h7a;
  localparam logic [7:0] PMC_IDX_PM_CAP_HDR = 8'hc0;

  // ==========================================================================
  // Capability header field positions
  localparam int unsigned PMC_CAP_IDENT_LSB    = 0;
  localparam int unsigned PMC_NEXT_PTR_LSB     = 8;
  localparam int unsigned PMC_SPEC_VERSION_LSB = 16;
  localparam int unsigned PMC_EVCLK_BIT        = 19;
  localparam int unsigned PMC_RSVD20_BIT       = 20;
  localparam int unsigned PMC_DEV_INIT_BIT     = 21;
  localparam int unsigned PMC_AUX_CURRENT_LSB  = 22;
  localparam int unsigned PMC_D1_BIT      = 25;
  localparam int unsigned PMC_D2_BIT      = 26;
  localparam int unsigned PMC_PME_SUP_LSB = 27;

  // ==========================================================================
  // Field values and reset values
  localparam logic [7:0] PMC_CAP_IDENT_VALUE    = 8'h01;
  localparam logic [7:0] PMC_NEXT_PTR_UPSTREAM  = 8'h00;
  localparam logic [7:0] PMC_NEXT_PTR_DOWNSTRM  = 8'hd0;
  localparam logic [2:0] PMC_SPEC_VERSION_VALUE = 3'h3;
  localparam logic       PMC_EVCLK_VALUE        = 1'h0;
  localparam logic       PMC_DEV_INIT_RESET     = 1'h0;
  localparam logic [2:0] PMC_AUX_CURRENT_VALUE  = 3'h0;
  localparam logic       PMC_D1_VALUE         = 1'h0;
  localparam logic       PMC_D2_VALUE         = 1'h0;
  localparam logic [4:0] PMC_PME_SUP_RESET    = 5'h19;
  localparam logic [31:0] PMC_RESERVED_VALUE  = 32'h0000_0000;

  // ==========================================================================
  // Power states and bus responses
  localparam logic [1:0] PMC_PSTATE_D0    = 2'h0;
  localparam logic [1:0] PMC_PSTATE_D3HOT = 2'h3;
  localparam logic [1:0] PMC_RESP_OKAY    = 2'h0;
  localparam logic [1:0] PMC_RESP_SLVERR  = 2'h2;

  typedef enum logic [2:0] {
    PMC_SEL_LINK_CTL2,
    PMC_SEL_LINK_STS2,
    PMC_SEL_SLOT_CAP2,
    PMC_SEL_SLOT_CTL2,
    PMC_SEL_SLOT_STS2,
    PMC_SEL_PM_CAP_HDR,
    PMC_SEL_NONE
  } pmc_sel_type;

endpackage : pmc_pkg

// File: tb/pmc_cfg_regs_checker.sv
// Assertion checker for the power management capability register slice
`timescale 1ns/1ns
module pmc_cfg_regs_checker
  import pmc_pkg::*;
(
  input wire logic        CLK,
  input wire logic        RST_N,
  input wire logic [1:0]  POWER_STATE,
  input wire logic        IN_D3COLD,
  input wire logic        PME_EVENT_IN,
  input wire logic        PME_FORWARD,
  input wire logic [11:0] ARADDR,
  input wire logic        ARVALID,
  input wire logic        ARREADY,
  input wire logic [31:0] RDATA,
  input wire logic [1:0]  RRESP,
  input wire logic        RVALID
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  logic hdr_rd;
  logic rsv_rd;
  assign hdr_rd = ARVALID && ARREADY && ARADDR == 12'h300;
  assign rsv_rd = ARVALID && ARREADY && ARADDR inside {12'h1c0, 12'h1c8, 12'h1d0, 12'h1e0, 12'h1e8};
  // ==========================================================================
  // Read values
  cap_ident_a: assert property (hdr_rd |=> RDATA[7:0] == PMC_CAP_IDENT_VALUE)
    else $error("capability id wrong");
  spec_version_a: assert property (hdr_rd |=> RDATA[18:16] == PMC_SPEC_VERSION_VALUE)
    else $error("version field wrong");
  ro_zero_a: assert property (hdr_rd |=> {RDATA[26:22], RDATA[20:19]} == 7'h0)
    else $error("read-only zero field set");
  rsvd_read_a: assert property (rsv_rd |=> RDATA == 32'h0 && RRESP == PMC_RESP_OKAY)
    else $error("reserved word not zero");
  hole_read_a: assert property (ARVALID && ARREADY && ARADDR[1:0] != 2'h0
      |=> RVALID && RRESP == PMC_RESP_SLVERR && RDATA == 32'h0)
    else $error("misaligned read not refused");
  // ==========================================================================
  // Event forwarding
  fwd_allowed_a: assert property (PME_EVENT_IN && !IN_D3COLD && POWER_STATE inside {2'h0, 2'h3}
      |=> PME_FORWARD)
    else $error("event not forwarded");
  cold_block_a: assert property (PME_FORWARD |-> $past(PME_EVENT_IN) && !$past(IN_D3COLD))
    else $error("forward without cause or in cold state");
  fwd_state_a: assert property (PME_FORWARD |-> $past(POWER_STATE) inside {2'h0, 2'h3})
    else $error("forward in unsupported state");
  cover property (PME_FORWARD);
  cover property (hdr_rd);
  cover property (rsv_rd);
endmodule : pmc_cfg_regs_checker

bind pmc_cfg_regs pmc_cfg_regs_checker u_chk (
  .CLK          (CLK),
  .RST_N        (RST_N),
  .POWER_STATE  (POWER_STATE),
  .IN_D3COLD    (IN_D3COLD),
  .PME_EVENT_IN (PME_EVENT_IN),
  .PME_FORWARD  (PME_FORWARD),
  .ARADDR       (ARADDR),
  .ARVALID      (ARVALID),
  .ARREADY      (ARREADY),
  .RDATA        (RDATA),
  .RRESP        (RRESP),
  .RVALID       (RVALID)
);

// File: tb/tb_pmc_cfg_regs.sv
// Self-checking testbench for the power management capability register slice
`timescale 1ns/1ns
module tb_pmc_cfg_regs;
  import pmc_pkg::*;
  logic        CLK, RST_N, IS_UPSTREAM, LOCKED_WRITE_EN, IN_D3COLD, PME_EVENT_IN, PME_FORWARD;
  logic [1:0]  POWER_STATE, BRESP, RRESP, r;
  logic [11:0] AWADDR, ARADDR;
  logic [31:0] WDATA, RDATA, d;
  logic [3:0]  WSTRB;
  logic        AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
  logic        ARVALID, ARREADY, RVALID, RREADY;
  int          error_cnt, num_checks, cyc;

  pmc_cfg_regs dut (
    .CLK             (CLK),
    .RST_N           (RST_N),
    .IS_UPSTREAM     (IS_UPSTREAM),
    .LOCKED_WRITE_EN (LOCKED_WRITE_EN),
    .POWER_STATE     (POWER_STATE),
    .IN_D3COLD       (IN_D3COLD),
    .PME_EVENT_IN    (PME_EVENT_IN),
    .PME_FORWARD     (PME_FORWARD),
    .AWADDR          (AWADDR),
    .AWVALID         (AWVALID),
    .AWREADY         (AWREADY),
    .WDATA           (WDATA),
    .WSTRB           (WSTRB),
    .WVALID          (WVALID),
    .WREADY          (WREADY),
    .BRESP           (BRESP),
    .BVALID          (BVALID),
    .BREADY          (BREADY),
    .ARADDR          (ARADDR),
    .ARVALID         (ARVALID),
    .ARREADY         (ARREADY),
    .RDATA           (RDATA),
    .RRESP           (RRESP),
    .RVALID          (RVALID),
    .RREADY          (RREADY)
  );

  initial begin
    CLK = 1'h0;
    forever #25 CLK = ~CLK;
  end

  // Hang guard: whole run needs under two hundred cycles
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  // ==========================================================================
  // Helpers
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [3:0] s);
    AWADDR <= a;
    WDATA <= v;
    WSTRB <= s;
    AWVALID <= 1'h1;
    WVALID <= 1'h1;
    BREADY <= 1'h1;
    do begin
      @(posedge CLK);
      if (AWVALID && AWREADY) AWVALID <= 1'h0;
      if (WVALID && WREADY) WVALID <= 1'h0;
    end while (!(BVALID && BREADY));
    r = BRESP;
    BREADY <= 1'h0;
    // Let an edge pass so a following call never re-raises in this step
    @(posedge CLK);
  endtask : wr

  task automatic rd(input logic [11:0] a);
    ARADDR <= a;
    ARVALID <= 1'h1;
    RREADY <= 1'h1;
    do begin
      @(posedge CLK);
      if (ARVALID && ARREADY) ARVALID <= 1'h0;
    end while (!(RVALID && RREADY));
    d = RDATA;
    r = RRESP;
    RREADY <= 1'h0;
    @(posedge CLK);
  endtask : rd

  // ==========================================================================
  // Scenarios
  task automatic t_defaults(input logic u);
    logic [11:0] rsv [5];
    rsv = '{12'h1c0, 12'h1c8, 12'h1d0, 12'h1e0, 12'h1e8};
    RST_N <= 1'h0;
    IS_UPSTREAM <= u;
    repeat (20) @(posedge CLK);
    RST_N <= 1'h1;
    @(posedge CLK);
    rd(12'h300);
    chk(d, {5'h19, 8'h0, 3'h3, u ? 8'h00 : 8'hd0, 8'h01});
    foreach (rsv[i]) begin
      wr(rsv[i], 32'hffff_ffff, 4'hf);
      chk({30'h0, r}, {30'h0, PMC_RESP_OKAY});
      rd(rsv[i]);
      chk(d, 32'h0);
      chk({30'h0, r}, {30'h0, PMC_RESP_OKAY});
    end
  endtask : t_defaults

  task automatic t_locked();
    LOCKED_WRITE_EN <= 1'h0;
    wr(12'h300, 32'hffff_ffff, 4'hf);
    rd(12'h300);
    chk(d, 32'hc803_d001);
    LOCKED_WRITE_EN <= 1'h1;
    wr(12'h300, 32'hffff_ffff, 4'hf);
    rd(12'h300);
    chk(d, {5'h1f, 5'h0, 1'h1, 2'h0, 3'h3, 8'hff, 8'h01});
    // Clear only the advertised event mask; forwarding must not follow it
    wr(12'h300, 32'h0, 4'h8);
    rd(12'h300);
    chk(d, {5'h00, 5'h0, 1'h1, 2'h0, 3'h3, 8'hff, 8'h01});
  endtask : t_locked

  task automatic t_holes();
    rd(12'h304);
    chk({30'h0, r}, {30'h0, PMC_RESP_SLVERR});
    chk(d, 32'h0);
    rd(12'h302);
    chk({30'h0, r}, {30'h0, PMC_RESP_SLVERR});
    wr(12'h304, 32'hffff_ffff, 4'hf);
    chk({30'h0, r}, {30'h0, PMC_RESP_SLVERR});
  endtask : t_holes

  task automatic t_fwd();
    for (int i = 0; i < 8; i++) begin
      POWER_STATE <= i[1:0];
      IN_D3COLD <= i[2];
      PME_EVENT_IN <= 1'h1;
      @(posedge CLK);
      PME_EVENT_IN <= 1'h0;
      #1;
      chk({31'h0, PME_FORWARD}, {31'h0, (i[1:0] == 2'h0 || i[1:0] == 2'h3) && !i[2]});
      @(posedge CLK);
      #1;
      chk({31'h0, PME_FORWARD}, 32'h0);
      @(posedge CLK);
    end
  endtask : t_fwd

  task automatic report_and_stop();
    $display("checks=%0d errors=%0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    {RST_N, IS_UPSTREAM, IN_D3COLD, PME_EVENT_IN, AWVALID, WVALID, BREADY} = 7'h0;
    {ARVALID, RREADY, POWER_STATE, AWADDR, ARADDR, WDATA, WSTRB} = 64'h0;
    LOCKED_WRITE_EN = 1'h1;
    @(posedge CLK);
    t_defaults(1'h1);
    t_defaults(1'h0);
    t_locked();
    t_holes();
    t_fwd();
    report_and_stop();
  end
endmodule : tb_pmc_cfg_regs
